// File: cpudec_map.svh
`ifndef CPUDEC_MAP_SVH
`define CPUDEC_MAP_SVH

// Opcodes with a sequence of their own
`define CD_OP_RTS        8'h81
`define CD_OP_DEBUG      8'h82
`define CD_OP_TRAP       8'h83
`define CD_OP_PRODUCT    8'h42
`define CD_OP_QUOTIENT   8'h52
`define CD_OP_CNTDN_DIR  8'h3b
`define CD_OP_CMPBR_IX1P 8'h61
`define CD_OP_COPY_DD    8'h4e
`define CD_OP_COPY_DIXP  8'h5e
`define CD_OP_COPY_IMD   8'h6e
`define CD_OP_COPY_IXPD  8'h7e
`define CD_OP_STOP       8'h8e
`define CD_OP_WAIT       8'h8f
`define CD_OP_PREFIX     8'h9e
`define CD_OP_PUSH_A     8'h87
`define CD_OP_PUSH_X     8'h89
`define CD_OP_PUSH_H     8'h8b

// Cycle counts, opcode fetch included
`define CD_CYC_BIT       4'h5
`define CD_CYC_RMW_DIR   4'h5
`define CD_CYC_TRAP      4'hb
`define CD_CYC_WAIT      4'h2
`define CD_CYC_DEBUG     4'h5
`define CD_CYC_PRODUCT   4'h5
`define CD_CYC_QUOTIENT  4'h6
`define CD_CYC_CNTDN_DIR 4'h7
`define CD_CYC_RTS       4'h6
`define CD_CYC_COPY_IMD  4'h4
`define CD_CYC_CMPBR     4'h5

// Remaining-cycle marks inside the trap and return sequences
`define CD_TRAP_PUSH_LAST 4'h6
`define CD_VEC_HI_CNT     4'h5
`define CD_VEC_LO_CNT     4'h4
`define CD_RTS_POP_LAST   4'h4

// Vector page and reset values
`define CD_VEC_PAGE      8'hff
`define CD_TRAP_VEC_LO   8'hfc
`define CD_RESET_VEC_LO  8'hfe
`define CD_SP_RESET      16'h00ff

// Flag update masks {overflow, half, negative, zero, carry}
`define CD_FLG_ARITH     5'h17
`define CD_FLG_ADD       5'h1f
`define CD_FLG_MOVE      5'h16
`define CD_FLG_CARRY     5'h01

`endif

// File: cpudec_pkg.sv
package cpudec_pkg;

	typedef enum logic [2:0] {
		K_FREE  = 3'h0,
		K_FETCH = 3'h1,
		K_READ  = 3'h2,
		K_WRITE = 3'h3,
		K_PUSH  = 3'h4,
		K_POP   = 3'h5,
		K_VECT  = 3'h6
	} cpudec_kind_t;

	typedef enum logic [3:0] {
		M_INH  = 4'h0,
		M_IMM  = 4'h1,
		M_DIR  = 4'h2,
		M_EXT  = 4'h3,
		M_IX2  = 4'h4,
		M_IX1  = 4'h5,
		M_IX   = 4'h6,
		M_IXP  = 4'h7,
		M_IX1P = 4'h8,
		M_SP2  = 4'h9,
		M_SP1  = 4'ha,
		M_REL  = 4'hb,
		M_DD   = 4'hc,
		M_DIXP = 4'hd,
		M_IMD  = 4'he,
		M_IXPD = 4'hf
	} cpudec_mode_t;

	typedef enum logic [4:0] {
		C_NONE  = 5'h00,
		C_ALU   = 5'h01,
		C_STORE = 5'h02,
		C_RMW   = 5'h03,
		C_BTST  = 5'h04,
		C_BFRC  = 5'h05,
		C_BRA   = 5'h06,
		C_COMPARE_BRANCH_EQUAL_OP  = 5'h07,
		C_COUNT_DOWN_BRANCH_OP  = 5'h08,
		C_COPY  = 5'h09,
		C_PUSH  = 5'h0a,
		C_POP   = 5'h0b,
		C_RTS   = 5'h0c,
		C_TRAP  = 5'h0d,
		C_WAIT  = 5'h0e,
		C_STOP  = 5'h0f,
		C_DBG   = 5'h10,
		C_PFX   = 5'h11,
		C_ILL   = 5'h12,
		C_JUMP  = 5'h13
	} cpudec_cls_t;

	typedef enum logic [2:0] {
		S_OPC   = 3'h0,
		S_OPND  = 3'h1,
		S_EXEC  = 3'h2,
		S_TRAP  = 3'h3,
		S_HOLD  = 3'h4,
		S_PAGE2 = 3'h5
	} cpudec_state_t;

	typedef struct packed {
		cpudec_cls_t  cls;
		cpudec_mode_t mode;
		logic [1:0]   len;
		logic [3:0]   cyc;
		logic [4:0]   flg;
	} cpudec_dec_t;

	typedef struct packed {
		logic [15:0]  addr;
		logic         rd;
		logic         wr;
		logic [7:0]   wdata;
		cpudec_kind_t kind;
	} cpudec_bus_t;

	typedef struct packed {
		logic mask_set;
		logic mask_clr;
		logic cond_hit;
		logic illegal;
		logic page2;
	} cpudec_evt_t;

	typedef struct packed {
		logic waiting;
		logic stopped;
		logic debug;
	} cpudec_stat_t;

	typedef struct packed {
		cpudec_state_t st;
		logic [15:0]   pc;
		logic [15:0]   sp;
		logic [15:0]   hx;
		logic [15:0]   ea;
		logic [15:0]   wa;
		logic [7:0]    op;
		logic [7:0]    o1;
		logic [7:0]    o2;
		logic [7:0]    tmp;
		logic [7:0]    pg2;
		logic [7:0]    vec;
		logic [3:0]    cnt;
		logic [1:0]    nop;
		logic          first;
		logic          hit;
		cpudec_dec_t   dec;
		cpudec_bus_t   bus;
		cpudec_evt_t   evt;
	} cpudec_st_t;

endpackage

// File: cpudec_core.sv
// Notes on behaviour
// [RQ1] 0x00-0x0F test bit, branch: 3 bytes, 5 cycles
// [RQ2] 0x10-0x1F force direct bit: 2 bytes, 5 cycles
// [RQ3] Free cycle: one clock, issued as read
// [RQ4] Program fetch reads next location, advances address
// [RQ5] Vector read from page FFxx, high first
// [RQ6] Push writes at stack, then pointer moves down
// [RQ7] Pop releases byte, then reads it
// [RQ8] Operand reads and writes move 8-bit data
// [RQ9] Post-increment index: pair address, then increment
// [RQ10] Wide stack mode: pointer plus 16-bit offset
// [RQ11] Columns A-F: imm, dir, ext, ix2, ix1, ix
// [RQ12] Columns 3-7: dir, acc, x, ix1, ix
// [RQ13] 0x83 trap: one byte, 11 cycles
// [RQ14] 0x8E stop: one byte, 2+ cycles
// [RQ15] 0x8F wait: one byte, 2+ cycles, held
// [RQ16] 0x42 multiply: one byte, 5 cycles
// [RQ17] 0x52 divide: one byte, 6 cycles
// [RQ18] 0x3B count down, branch: 3 bytes, 7 cycles
// [RQ19] 0x81 return 6 cycles; 0x82 debug 5+
// [RQ20] Copy opcodes 0x4E, 0x5E, 0x6E, 0x7E
// [RQ21] 0x61 compare, branch equal: 3 bytes, 5 cycles
// [RQ22] 0x9E selects second opcode page
// [RQ23] Trap pushes five bytes, masks, loads vector
// [RQ24] Wait clears interrupt mask before halting
// [RQ25] Empty opcodes go to reset vector path
// [RQ26] Flags updated only per instruction mask
`timescale 1ns/1ps
`include "cpudec_map.svh"

module cpudec_core
	import cpudec_pkg::*;
#(
	parameter logic [7:0] TRAP_VEC_LO  = `CD_TRAP_VEC_LO,
	parameter logic [7:0] RESET_VEC_LO = `CD_RESET_VEC_LO
)(
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         arst_n,
	// System bus
	input  wire logic [7:0]   bus_rdata,
	output cpudec_bus_t       bus,
	// Data from the execution unit
	input  wire logic [7:0]   acc_in,
	input  wire logic [7:0]   flags_in,
	input  wire logic [7:0]   result_byte,
	// Release of low-power and debug states
	input  wire logic         irq_req,
	input  wire logic         dbg_exit,
	// Decode results and events
	output cpudec_dec_t       dec,
	output logic [7:0]        opcode,
	output logic [7:0]        page2_op,
	output cpudec_evt_t       evt,
	output cpudec_stat_t      stat,
	output logic [15:0]       pc,
	output logic [15:0]       sp,
	output logic [15:0]       hx
);

	// Vectors are word pairs, high byte on the even address
	if (TRAP_VEC_LO[0] != 1'b0 || RESET_VEC_LO[0] != 1'b0)
	begin : g_chk
		$error("vector offsets must be even");
	end

	localparam cpudec_st_t RST = '{
		st: S_TRAP, pc: 16'h0000, sp: `CD_SP_RESET, hx: 16'h0000,
		ea: 16'h0000, wa: 16'h0000, op: 8'h00, o1: 8'h00, o2: 8'h00,
		tmp: 8'h00, pg2: 8'h00, vec: RESET_VEC_LO, cnt: `CD_VEC_HI_CNT,
		nop: 2'h0, first: 1'b0, hit: 1'b0,
		dec: '{cls: C_NONE, mode: M_INH, len: 2'h1, cyc: 4'h1, flg: 5'h00},
		bus: '{addr: {`CD_VEC_PAGE, RESET_VEC_LO}, rd: 1'b1, wr: 1'b0, wdata: 8'h00, kind: K_VECT},
		evt: '0
	};

	cpudec_st_t s_q;
	cpudec_st_t s_d;

	function automatic cpudec_dec_t mk(cpudec_cls_t c, cpudec_mode_t m, logic [1:0] l, logic [3:0] y);
		cpudec_dec_t r;
		r.cls  = c;
		r.mode = m;
		r.len  = l;
		r.cyc  = y;
		r.flg  = 5'h00;
		return r;
	endfunction

	function automatic cpudec_dec_t decode(logic [7:0] op);
		cpudec_dec_t d;
		d = mk(C_ILL, M_INH, 2'h1, 4'h1);
		case (op[7:4])
			4'h0: d = mk(C_BTST, M_DIR, 2'h3, `CD_CYC_BIT); // see [RQ1]
			4'h1: d = mk(C_BFRC, M_DIR, 2'h2, `CD_CYC_BIT); // see [RQ2]
			4'h2: d = mk(C_BRA, M_REL, 2'h2, 4'h3);
			4'h3: d = mk(C_RMW, M_DIR, 2'h2, `CD_CYC_RMW_DIR); // see [RQ12]
			4'h4, 4'h5: d = mk(C_NONE, M_INH, 2'h1, 4'h1); // see [RQ12]
			4'h6: d = mk(C_RMW, M_IX1, 2'h2, 4'h5);
			4'h7: d = mk(C_RMW, M_IX, 2'h1, 4'h4);
			4'ha: d = mk(C_ALU, M_IMM, 2'h2, 4'h2); // see [RQ11]
			4'hb: d = mk(C_ALU, M_DIR, 2'h2, 4'h3);
			4'hc: d = mk(C_ALU, M_EXT, 2'h3, 4'h4);
			4'hd: d = mk(C_ALU, M_IX2, 2'h3, 4'h4);
			4'he: d = mk(C_ALU, M_IX1, 2'h2, 4'h3);
			4'hf: d = mk(C_ALU, M_IX, 2'h1, 4'h3);
			default: d = mk(C_ILL, M_INH, 2'h1, 4'h1);
		endcase
		if (op[7:4] >= 4'ha)
		begin
			if (op[3:0] == 4'h7 || op[3:0] == 4'hf)
				d.cls = (d.mode == M_IMM) ? C_NONE : C_STORE;
			else if (op[3:0] == 4'hc || op[3:0] == 4'hd)
				d.cls = C_JUMP;
		end
		case (op)
			8'h31: d = mk(C_COMPARE_BRANCH_EQUAL_OP, M_DIR, 2'h3, 4'h5);
			8'h41, 8'h51: d = mk(C_COMPARE_BRANCH_EQUAL_OP, M_IMM, 2'h3, 4'h4);
			`CD_OP_CMPBR_IX1P: d = mk(C_COMPARE_BRANCH_EQUAL_OP, M_IX1P, 2'h3, `CD_CYC_CMPBR); // see [RQ21]
			8'h71: d = mk(C_COMPARE_BRANCH_EQUAL_OP, M_IXP, 2'h2, 4'h5);
			8'h32: d = mk(C_ALU, M_EXT, 2'h3, 4'h5);
			8'h3e: d = mk(C_ALU, M_EXT, 2'h3, 4'h6);
			8'h35: d = mk(C_STORE, M_DIR, 2'h2, 4'h4);
			8'h45, 8'h65: d = mk(C_NONE, M_IMM, 2'h3, 4'h3);
			8'h55: d = mk(C_ALU, M_DIR, 2'h2, 4'h4);
			8'h75: d = mk(C_ALU, M_DIR, 2'h2, 4'h5);
			`CD_OP_CNTDN_DIR: d = mk(C_COUNT_DOWN_BRANCH_OP, M_DIR, 2'h3, `CD_CYC_CNTDN_DIR); // see [RQ18]
			8'h4b, 8'h5b: d = mk(C_COUNT_DOWN_BRANCH_OP, M_INH, 2'h2, 4'h4);
			8'h6b: d = mk(C_COUNT_DOWN_BRANCH_OP, M_IX1, 2'h3, 4'h7);
			8'h7b: d = mk(C_COUNT_DOWN_BRANCH_OP, M_IX, 2'h2, 4'h6);
			8'h3d: d = mk(C_ALU, M_DIR, 2'h2, 4'h4);
			8'h6d: d = mk(C_ALU, M_IX1, 2'h2, 4'h4);
			8'h7d: d = mk(C_ALU, M_IX, 2'h1, 4'h3);
			`CD_OP_PRODUCT: d = mk(C_NONE, M_INH, 2'h1, `CD_CYC_PRODUCT); // see [RQ16]
			`CD_OP_QUOTIENT: d = mk(C_NONE, M_INH, 2'h1, `CD_CYC_QUOTIENT); // see [RQ17]
			8'h62, 8'h72: d = mk(C_NONE, M_INH, 2'h1, 4'h1);
			`CD_OP_COPY_DD: d = mk(C_COPY, M_DD, 2'h3, 4'h5); // see [RQ20]
			`CD_OP_COPY_DIXP: d = mk(C_COPY, M_DIXP, 2'h2, 4'h5); // see [RQ20]
			`CD_OP_COPY_IMD: d = mk(C_COPY, M_IMD, 2'h3, `CD_CYC_COPY_IMD); // see [RQ20]
			`CD_OP_COPY_IXPD: d = mk(C_COPY, M_IXPD, 2'h2, 4'h5); // see [RQ20]
			`CD_OP_RTS: d = mk(C_RTS, M_INH, 2'h1, `CD_CYC_RTS); // see [RQ19]
			`CD_OP_DEBUG: d = mk(C_DBG, M_INH, 2'h1, `CD_CYC_DEBUG); // see [RQ19]
			`CD_OP_TRAP: d = mk(C_TRAP, M_INH, 2'h1, `CD_CYC_TRAP); // see [RQ13]
			8'h84, 8'h85, 8'h8c: d = mk(C_NONE, M_INH, 2'h1, 4'h1);
			8'h86, 8'h88, 8'h8a: d = mk(C_POP, M_INH, 2'h1, 4'h3);
			`CD_OP_PUSH_A, `CD_OP_PUSH_X, `CD_OP_PUSH_H: d = mk(C_PUSH, M_INH, 2'h1, 4'h2);
			`CD_OP_STOP: d = mk(C_STOP, M_INH, 2'h1, `CD_CYC_WAIT); // see [RQ14]
			`CD_OP_WAIT: d = mk(C_WAIT, M_INH, 2'h1, `CD_CYC_WAIT); // see [RQ15]
			8'h90, 8'h91, 8'h92, 8'h93: d = mk(C_BRA, M_REL, 2'h2, 4'h3);
			8'h94, 8'h95: d = mk(C_NONE, M_INH, 2'h1, 4'h2);
			8'h96: d = mk(C_STORE, M_EXT, 2'h3, 4'h5);
			8'h97, 8'h98, 8'h99, 8'h9a, 8'h9b, 8'h9c, 8'h9d, 8'h9f: d = mk(C_NONE, M_INH, 2'h1, 4'h1);
			`CD_OP_PREFIX: d = mk(C_PFX, M_INH, 2'h1, 4'h1); // see [RQ22]
			8'hac: d = mk(C_ILL, M_INH, 2'h1, 4'h1); // see [RQ25]
			8'had: d = mk(C_JUMP, M_REL, 2'h2, 4'h5);
			8'hbd, 8'hed, 8'hfd: d.cyc = 4'h5;
			8'hcd, 8'hdd: d.cyc = 4'h6;
			8'hf7, 8'hff: d.cyc = 4'h2;
			default: d.cyc = d.cyc;
		endcase
		// Only listed flags may change; the rest hold
		case (d.cls)
			C_ALU, C_RMW, C_COMPARE_BRANCH_EQUAL_OP: d.flg = (op[7:4] >= 4'ha && (op[3:0] == 4'h9 || op[3:0] == 4'hb))
				? `CD_FLG_ADD : `CD_FLG_ARITH; // see [RQ26]
			C_STORE, C_COPY: d.flg = `CD_FLG_MOVE; // see [RQ26]
			C_BTST: d.flg = `CD_FLG_CARRY; // see [RQ26]
			default: d.flg = 5'h00;
		endcase
		return d;
	endfunction

	function automatic logic [15:0] addr_of(cpudec_mode_t m, logic [7:0] a, logic [7:0] b,
		logic [15:0] x, logic [15:0] p);
		case (m)
			M_DIR, M_DD, M_DIXP, M_IMD: return {8'h00, a};
			M_EXT: return {a, b};
			M_IX2: return x + {a, b};
			M_IX1, M_IX1P: return x + {8'h00, a};
			M_IX, M_IXP, M_IXPD: return x; // see [RQ9]
			M_SP2: return p + {a, b}; // see [RQ10]
			M_SP1: return p + {8'h00, a};
			default: return 16'h0000;
		endcase
	endfunction

	logic mem_md;
	logic rd_cls;
	logic wr_cls;
	logic [7:0] push_byte;

	always_comb
	begin
		s_d = s_q;
		s_d.evt = '0;
		if (s_q.bus.kind == K_READ || s_q.bus.kind == K_POP)
			s_d.tmp = bus_rdata; // see [RQ8]
		case (s_q.st)
			S_OPC:
			begin
				s_d.op = bus_rdata;
				s_d.dec = decode(bus_rdata);
				s_d.nop = 2'h0;
				s_d.first = 1'b1;
				s_d.hit = 1'b0;
				s_d.cnt = s_d.dec.cyc - 4'h1;
				case (s_d.dec.cls)
					C_ILL:
					begin
						// No empty opcode ever runs; it restarts through the reset vector
						s_d.evt.illegal = 1'b1; // see [RQ25]
						s_d.st = S_TRAP;
						s_d.cnt = `CD_VEC_HI_CNT;
						s_d.vec = RESET_VEC_LO;
					end
					C_PFX: s_d.st = S_PAGE2; // see [RQ22]
					C_TRAP:
					begin
						s_d.st = S_TRAP; // see [RQ13]
						s_d.vec = TRAP_VEC_LO;
					end
					C_WAIT, C_STOP, C_DBG:
					begin
						s_d.st = S_HOLD;
						s_d.evt.mask_clr = (s_d.dec.cls == C_WAIT); // see [RQ24]
					end
					default:
					begin
						if (s_d.dec.len > 2'h1)
							s_d.st = S_OPND;
						else if (s_d.cnt == 4'h0)
							s_d.st = S_OPC;
						else
						begin
							s_d.st = S_EXEC;
							s_d.ea = addr_of(s_d.dec.mode, s_d.o1, s_d.o2, s_d.hx, s_d.sp);
							s_d.wa = s_d.ea;
						end
					end
				endcase
			end
			S_OPND:
			begin
				if (s_q.nop == 2'h0)
					s_d.o1 = bus_rdata;
				else
					s_d.o2 = bus_rdata;
				s_d.nop = s_q.nop + 2'h1;
				if (s_d.nop != s_q.dec.len - 2'h1)
				begin
					if (s_q.cnt > 4'h1)
						s_d.cnt = s_q.cnt - 4'h1;
				end
				else if (s_q.cnt <= 4'h1)
					s_d.st = S_OPC;
				else
				begin
					s_d.cnt = s_q.cnt - 4'h1;
					s_d.st = S_EXEC;
					s_d.ea = addr_of(s_q.dec.mode, s_d.o1, s_d.o2, s_q.hx, s_q.sp);
					case (s_q.dec.mode)
						M_DD, M_IMD: s_d.wa = {8'h00, s_d.o2}; // see [RQ20]
						M_DIXP: s_d.wa = s_q.hx;
						M_IXPD: s_d.wa = {8'h00, s_d.o1};
						default: s_d.wa = s_d.ea;
					endcase
				end
			end
			S_EXEC:
			begin
				s_d.first = 1'b0;
				if (s_q.bus.kind == K_READ && s_q.dec.cls == C_BTST)
					s_d.hit = bus_rdata[s_q.op[3:1]] ^ s_q.op[0]; // see [RQ1]
				if (s_q.bus.kind == K_POP && s_q.dec.cls == C_RTS)
				begin
					if (s_q.cnt == `CD_VEC_HI_CNT)
						s_d.pc[15:8] = bus_rdata;
					else
						s_d.pc[7:0] = bus_rdata;
				end
				if (s_q.cnt <= 4'h1)
				begin
					s_d.st = S_OPC;
					if (s_q.dec.cls == C_BTST && s_d.hit)
					begin
						s_d.pc = s_d.pc + {{8{s_q.o2[7]}}, s_q.o2}; // see [RQ1]
						s_d.evt.cond_hit = 1'b1;
					end
				end
				else
					s_d.cnt = s_q.cnt - 4'h1;
			end
			S_TRAP:
			begin
				if (s_q.bus.kind == K_VECT)
				begin
					if (s_q.cnt == `CD_VEC_HI_CNT)
						s_d.pc[15:8] = bus_rdata; // see [RQ5]
					else
						s_d.pc[7:0] = bus_rdata;
				end
				if (s_q.cnt <= 4'h1)
					s_d.st = S_OPC;
				else
					s_d.cnt = s_q.cnt - 4'h1;
			end
			S_HOLD:
			begin
				// The least count runs out first, then only a release ends the state
				if (s_q.cnt > 4'h1)
					s_d.cnt = s_q.cnt - 4'h1; // see [RQ14] [RQ15] [RQ19]
				else if ((s_q.dec.cls == C_DBG) ? dbg_exit : irq_req)
					s_d.st = S_OPC;
			end
			S_PAGE2:
			begin
				// Second-page execution belongs to the page-two decoder
				s_d.pg2 = bus_rdata; // see [RQ22]
				s_d.evt.page2 = 1'b1;
				s_d.st = S_OPC;
			end
			default: s_d.st = S_OPC;
		endcase

		mem_md = !(s_d.dec.mode inside {M_INH, M_IMM, M_REL});
		rd_cls = ((s_d.dec.cls inside {C_ALU, C_RMW, C_BTST, C_BFRC, C_COMPARE_BRANCH_EQUAL_OP, C_COUNT_DOWN_BRANCH_OP}) && mem_md)
			|| (s_d.dec.cls == C_COPY && s_d.dec.mode != M_IMD);
		wr_cls = (s_d.dec.cls inside {C_STORE, C_BFRC, C_COPY})
			|| ((s_d.dec.cls inside {C_RMW, C_COUNT_DOWN_BRANCH_OP}) && mem_md);
		case (s_d.cnt)
			4'ha: push_byte = s_d.pc[7:0]; // see [RQ23]
			4'h9: push_byte = s_d.pc[15:8];
			4'h8: push_byte = s_d.hx[7:0];
			4'h7: push_byte = acc_in;
			default: push_byte = flags_in;
		endcase
		if (s_d.st == S_EXEC && s_d.dec.cls == C_PUSH)
			push_byte = (s_d.op == `CD_OP_PUSH_A) ? acc_in
				: (s_d.op == `CD_OP_PUSH_X) ? s_d.hx[7:0] : s_d.hx[15:8];

		// A free cycle still drives a read at the program counter
		s_d.bus = '{addr: s_d.pc, rd: 1'b1, wr: 1'b0, wdata: 8'h00, kind: K_FREE}; // see [RQ3]
		case (s_d.st)
			S_OPC, S_OPND, S_PAGE2:
			begin
				s_d.bus.kind = K_FETCH; // see [RQ4]
				s_d.pc = s_d.pc + 16'h0001;
			end
			S_EXEC:
			begin
				if ((s_d.dec.cls == C_PUSH && s_d.first)
					|| (s_d.dec.cls == C_TRAP))
					s_d.bus.kind = K_PUSH;
				else if ((s_d.dec.cls == C_POP && s_d.first)
					|| (s_d.dec.cls == C_RTS && s_d.cnt >= `CD_RTS_POP_LAST))
					s_d.bus.kind = K_POP;
				else if (s_d.first && rd_cls)
				begin
					s_d.bus.kind = K_READ; // see [RQ8]
					s_d.bus.addr = s_d.ea;
					if (s_d.dec.mode inside {M_IXP, M_IX1P, M_IXPD})
						s_d.hx = s_d.hx + 16'h0001; // see [RQ9]
				end
				else if (s_d.cnt == 4'h1 && wr_cls)
				begin
					s_d.bus.kind = K_WRITE; // see [RQ8]
					s_d.bus.rd = 1'b0;
					s_d.bus.wr = 1'b1;
					s_d.bus.addr = s_d.wa;
					if (s_d.dec.cls == C_BFRC)
						s_d.bus.wdata = s_d.op[0] ? (s_d.tmp & ~(8'h01 << s_d.op[3:1]))
							: (s_d.tmp | (8'h01 << s_d.op[3:1])); // see [RQ2]
					else if (s_d.dec.cls == C_COPY)
						s_d.bus.wdata = (s_d.dec.mode == M_IMD) ? s_d.o1 : s_d.tmp; // see [RQ20]
					else
						s_d.bus.wdata = result_byte;
					if (s_d.dec.mode == M_DIXP)
						s_d.hx = s_d.hx + 16'h0001; // see [RQ9]
				end
			end
			S_TRAP:
			begin
				if (s_d.cnt >= `CD_TRAP_PUSH_LAST)
					s_d.bus.kind = K_PUSH; // see [RQ23]
				else if (s_d.cnt >= `CD_VEC_LO_CNT)
				begin
					s_d.bus.kind = K_VECT; // see [RQ5]
					s_d.bus.addr = {`CD_VEC_PAGE, s_d.vec | {7'h00, s_d.cnt == `CD_VEC_LO_CNT}};
					s_d.evt.mask_set = (s_d.cnt == `CD_VEC_HI_CNT); // see [RQ23]
				end
			end
			default: s_d.bus.kind = K_FREE;
		endcase
		if (s_d.bus.kind == K_PUSH)
		begin
			s_d.bus.rd = 1'b0;
			s_d.bus.wr = 1'b1;
			s_d.bus.addr = s_d.sp;
			s_d.bus.wdata = push_byte;
			s_d.sp = s_d.sp - 16'h0001; // see [RQ6]
		end
		else if (s_d.bus.kind == K_POP)
		begin
			s_d.sp = s_d.sp + 16'h0001; // see [RQ7]
			s_d.bus.addr = s_d.sp;
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			s_q <= RST;
		else
			s_q <= s_d;
	end

	assign bus = s_q.bus;
	assign dec = s_q.dec;
	assign opcode = s_q.op;
	assign page2_op = s_q.pg2;
	assign evt = s_q.evt;
	assign stat = '{waiting: s_q.st == S_HOLD && s_q.dec.cls == C_WAIT,
		stopped: s_q.st == S_HOLD && s_q.dec.cls == C_STOP,
		debug: s_q.st == S_HOLD && s_q.dec.cls == C_DBG};
	assign pc = s_q.pc;
	assign sp = s_q.sp;
	assign hx = s_q.hx;

endmodule

// File: cpudec_asserts.sv
`timescale 1ns/1ps
module cpudec_asserts
	import cpudec_pkg::*;
#(
	parameter logic [7:0] TRAP_VEC_LO  = 8'hfc,
	parameter logic [7:0] RESET_VEC_LO = 8'hfe
)(
	// Clock and reset
	input wire logic         clk,
	input wire logic         arst_n,
	// System bus
	input wire logic [7:0]   bus_rdata,
	input wire cpudec_bus_t  bus,
	// Execution unit and release
	input wire logic [7:0]   acc_in,
	input wire logic [7:0]   flags_in,
	input wire logic [7:0]   result_byte,
	input wire logic         irq_req,
	input wire logic         dbg_exit,
	// Decode results
	input wire cpudec_dec_t  dec,
	input wire logic [7:0]   opcode,
	input wire logic [7:0]   page2_op,
	input wire cpudec_evt_t  evt,
	input wire cpudec_stat_t stat,
	input wire logic [15:0]  pc,
	input wire logic [15:0]  sp,
	input wire logic [15:0]  hx
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);

	free_is_read_a: assert property (bus.kind == K_FREE |-> bus.rd && !bus.wr)
		else $error("free cycle not a read");
	write_kind_a: assert property (bus.wr |-> !bus.rd && (bus.kind == K_WRITE || bus.kind == K_PUSH))
		else $error("write strobe on a non-write cycle");
	vect_page_a: assert property (bus.kind == K_VECT |-> bus.rd && bus.addr[15:8] == 8'hff)
		else $error("vector read off the top page");
	vect_order_a: assert property (bus.kind == K_VECT && !bus.addr[0]
		|=> bus.kind == K_VECT && bus.addr == $past(bus.addr) + 16'h1)
		else $error("vector low byte not after high byte");
	fetch_seq_a: assert property (bus.kind == K_FETCH ##1 (bus.kind == K_FETCH && !evt.cond_hit)
		|-> bus.addr == $past(bus.addr) + 16'h1)
		else $error("fetch address not sequential");
	push_down_a: assert property (bus.kind == K_PUSH ##1 bus.kind == K_PUSH
		|-> bus.addr == $past(bus.addr) - 16'h1)
		else $error("pushes not moving down the stack");
	pop_up_a: assert property (bus.kind == K_POP ##1 bus.kind == K_POP
		|-> bus.addr == $past(bus.addr) + 16'h1)
		else $error("pops not moving up the stack");
	mask_vect_a: assert property (evt.mask_set |-> bus.kind == K_VECT && !bus.addr[0])
		else $error("mask set away from vector high read");
	trap_seq_a: assert property (bus.kind == K_FETCH && bus_rdata == 8'h83 |=> (bus.kind == K_PUSH) [*5]
		##1 (bus.kind == K_VECT && bus.addr == {8'hff, TRAP_VEC_LO}) ##1 bus.kind == K_VECT
		##1 (bus.kind == K_FREE) [*3] ##1 bus.kind == K_FETCH)
		else $error("trap sequence wrong");
	rmw_dir_a: assert property (bus.kind == K_FETCH && bus_rdata == 8'h30 ##1 bus.kind == K_FETCH
		|=> bus.kind == K_READ ##1 bus.kind == K_FREE ##1 bus.kind == K_WRITE ##1 bus.kind == K_FETCH)
		else $error("direct read-modify-write sequence wrong");
	wait_hold_a: assert property (stat.waiting && !irq_req |=> stat.waiting && bus.kind == K_FREE)
		else $error("wait left without release");
	wait_exit_a: assert property (stat.waiting && irq_req |=> !stat.waiting && bus.kind == K_FETCH)
		else $error("wait not left on release");
	mask_clr_a: assert property ($rose(stat.waiting) |-> evt.mask_clr)
		else $error("mask not cleared on entering wait");
	illegal_vec_a: assert property (evt.illegal
		|-> ##[0:2] (bus.kind == K_VECT && bus.addr == {8'hff, RESET_VEC_LO}))
		else $error("empty opcode not routed to reset vector");
endmodule

bind cpudec_core cpudec_asserts #(
	.TRAP_VEC_LO  (TRAP_VEC_LO),
	.RESET_VEC_LO (RESET_VEC_LO)
) chk_i (.*);

// File: cpudec_mem.sv
`timescale 1ns/1ps
module cpudec_mem
	import cpudec_pkg::*;
(
	// Clock
	input  wire logic        clk,
	// System bus
	input  wire cpudec_bus_t bus,
	output logic [7:0]       bus_rdata
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_q;

	// Empty cells hold a no-operation so a stray fetch still decodes
	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'h9d;
	end

	// Zero wait states; on write cycles the line flips instead of holding old data
	always_comb
		bus_rdata = bus.rd ? mem[bus.addr] : ~last_q;

	always @(posedge clk)
	begin
		last_q <= bus_rdata;
		if (bus.wr)
			mem[bus.addr] <= bus.wdata;
	end
endmodule

// File: cpudec_tb.sv
`timescale 1ns/1ps
module tb
	import cpudec_pkg::*;
;
	logic         clk;
	logic         arst_n;
	logic [7:0]   bus_rdata;
	cpudec_bus_t  bus;
	logic [7:0]   acc_in;
	logic [7:0]   flags_in;
	logic [7:0]   result_byte;
	logic         irq_req;
	logic         dbg_exit;
	cpudec_dec_t  dec;
	logic [7:0]   opcode;
	logic [7:0]   page2_op;
	cpudec_evt_t  evt;
	cpudec_stat_t stat;
	logic [15:0]  pc;
	logic [15:0]  sp;
	logic [15:0]  hx;
	int           n_mismatch;
	int           n_checks;

	cpudec_core uut (.clk(clk), .arst_n(arst_n), .bus_rdata(bus_rdata), .bus(bus), .acc_in(acc_in),
		.flags_in(flags_in), .result_byte(result_byte), .irq_req(irq_req), .dbg_exit(dbg_exit),
		.dec(dec), .opcode(opcode), .page2_op(page2_op), .evt(evt), .stat(stat), .pc(pc), .sp(sp), .hx(hx));
	cpudec_mem mem_i (.clk(clk), .bus(bus), .bus_rdata(bus_rdata));

	always #12.5 clk = ~clk;

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t %s", $time, msg);
		end
	endtask

	// Free cycles carry the program counter as address, but only their read strobe is judged
	task automatic step(input cpudec_kind_t k, input logic [15:0] a);
		@(negedge clk);
		chk(bus.kind === k && (k == K_FREE ? bus.rd === 1'b1 : bus.addr === a), "bus cycle");
	endtask

	task automatic wait_kind(input cpudec_kind_t k, input int lim);
		for (int i = 0; i < lim && bus.kind !== k; i++)
			@(negedge clk);
		chk(bus.kind === k, "wait timed out");
		if (bus.kind !== k)
			finish_test();
	endtask

	task automatic sc_reset();
		repeat (2) @(negedge clk);
		chk(bus.kind === K_VECT && bus.addr === 16'hfffe && sp === 16'h00ff, "reset state");
		arst_n = 1'b1;
		step(K_VECT, 16'hffff);
		@(negedge clk);
		wait_kind(K_FETCH, 5);
		chk(bus.addr === 16'h0100, "first fetch");
	endtask

	task automatic sc_rmw();
		step(K_FETCH, 16'h0101);
		chk(dec.cyc === 4'h5 && dec.len === 2'h2 && dec.mode === M_DIR, "rmw decode");
		chk(opcode === 8'h30 && dec.flg === 5'h17 && hx === 16'h0000, "rmw opcode and flag mask");
		step(K_READ, 16'h0040);
		step(K_FREE, 16'h0000);
		step(K_WRITE, 16'h0040);
		chk(bus.wdata === 8'h01, "rmw write data");
		step(K_FETCH, 16'h0102);
	endtask

	task automatic sc_copy();
		step(K_FETCH, 16'h0103);
		chk(dec.cyc === 4'h4 && dec.len === 2'h3 && dec.mode === M_IMD, "copy decode");
		step(K_FETCH, 16'h0104);
		step(K_WRITE, 16'h0041);
		chk(bus.wdata === 8'h5a, "copy data");
		step(K_FETCH, 16'h0105);
	endtask

	task automatic sc_bit();
		step(K_FETCH, 16'h0106);
		chk(dec.cyc === 4'h5 && dec.len === 2'h3 && dec.cls === C_BTST, "bit test decode");
		step(K_FETCH, 16'h0107);
		step(K_READ, 16'h0040);
		step(K_FREE, 16'h0000);
		step(K_FETCH, 16'h010b);
		chk(evt.cond_hit === 1'b1, "branch taken");
	endtask

	task automatic sc_trap();
		logic [7:0] exp [5];
		exp = '{8'h0c, 8'h01, 8'h00, 8'h3c, 8'h65};
		for (int i = 0; i < 5; i++)
		begin
			step(K_PUSH, 16'h00ff - 16'(i));
			chk(bus.wr === 1'b1 && bus.wdata === exp[i], "pushed byte");
		end
		step(K_VECT, 16'hfffc);
		chk(evt.mask_set === 1'b1, "mask set");
		step(K_VECT, 16'hfffd);
		repeat (3) step(K_FREE, 16'h0000);
		step(K_FETCH, 16'h0200);
		chk(sp === 16'h00fa && pc === 16'h0201, "stack and counter after trap");
	endtask

	task automatic sc_wait();
		step(K_FREE, 16'h0000);
		chk(stat.waiting === 1'b1 && evt.mask_clr === 1'b1 && dec.cyc === 4'h2, "wait entry");
		repeat (4) step(K_FREE, 16'h0000);
		chk(stat.waiting === 1'b1, "still waiting");
		irq_req = 1'b1;
		step(K_FETCH, 16'h0201);
		irq_req = 1'b0;
	endtask

	task automatic sc_prefix();
		step(K_FETCH, 16'h0202);
		step(K_FETCH, 16'h0203);
		chk(evt.page2 === 1'b1 && page2_op === 8'h60, "second page byte");
	endtask

	// The vector read follows the empty opcode at once, in the cycle of the pulse; no push may come between
	task automatic sc_illegal();
		step(K_VECT, 16'hfffe);
		chk(evt.illegal === 1'b1 && evt.mask_set === 1'b1, "empty opcode flagged");
		step(K_VECT, 16'hffff);
		repeat (3) step(K_FREE, 16'h0000);
		step(K_FETCH, 16'h0100);
	endtask

	initial
	begin
		clk = 1'b0;
		arst_n = 1'b0;
		acc_in = 8'h3c;
		flags_in = 8'h65;
		result_byte = 8'h01;
		irq_req = 1'b0;
		dbg_exit = 1'b0;
		n_mismatch = 0;
		n_checks = 0;
		#1;
		{mem_i.mem[16'hfffe], mem_i.mem[16'hffff]} = 16'h0100;
		{mem_i.mem[16'hfffc], mem_i.mem[16'hfffd]} = 16'h0200;
		{mem_i.mem[16'h0100], mem_i.mem[16'h0101]} = 16'h3040;
		{mem_i.mem[16'h0102], mem_i.mem[16'h0103], mem_i.mem[16'h0104]} = 24'h6e5a41;
		{mem_i.mem[16'h0105], mem_i.mem[16'h0106], mem_i.mem[16'h0107]} = 24'h004003;
		mem_i.mem[16'h010b] = 8'h83;
		{mem_i.mem[16'h0200], mem_i.mem[16'h0201], mem_i.mem[16'h0202]} = 24'h8f9e60;
		mem_i.mem[16'h0203] = 8'h80;
		sc_reset();
		sc_rmw();
		sc_copy();
		sc_bit();
		sc_trap();
		sc_wait();
		sc_prefix();
		sc_illegal();
		finish_test();
	end
endmodule
